// ### src/ppp_pkg.sv
// Package for the parallel programming port: encodings, geometry, timing.
// Assumes a 50 MHz system clock; memories are modelled behind simple ports.
package ppp_pkg;
  // ==========================================================
  // Action select and commands
  localparam logic [1:0] PPP_ACT_ADDR = 2'h0;
  localparam logic [1:0] PPP_ACT_DATA = 2'h1;
  localparam logic [1:0] PPP_ACT_CMD = 2'h2;
  localparam logic [7:0] PPP_CMD_NOP = 8'h00;
  localparam logic [7:0] PPP_CMD_ERASE = 8'h80;
  localparam logic [7:0] PPP_CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] PPP_CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] PPP_CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] PPP_CMD_WR_EE = 8'h11;
  localparam logic [7:0] PPP_CMD_RD_SIG = 8'h08;
  localparam logic [7:0] PPP_CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] PPP_CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] PPP_CMD_RD_EE = 8'h03;
  // ==========================================================
  // Geometry and reset values
  localparam int PPP_FLASH_PAGE_WORDS = 128;
  localparam int PPP_FLASH_PAGES = 1024;
  localparam int PPP_EE_PAGE_BYTES = 8;
  localparam int PPP_EE_PAGES = 512;
  localparam logic [7:0] PPP_ERASED = 8'hFF;
  localparam int PPP_PRESERVE_BIT = 3;
  // ==========================================================
  // Timing
  localparam int PPP_CLK_MHZ = 50;
  localparam int PPP_PROG_TIME_US = 100;
  localparam int PPP_PROG_CYCLES = PPP_PROG_TIME_US * PPP_CLK_MHZ;
endpackage : ppp_pkg

// ### src/ppp_port.sv
// Parallel programming port: strobe decode, command/address/data latches,
// page buffers, fuse/lock storage and busy timing.
// Assumes all pins already synchronous to sys_clk; memory arrays are internal.
`timescale 1ns/1ns
module ppp_port
  import ppp_pkg::*;
#(
  parameter int PROG_CYCLES = PPP_PROG_CYCLES,
  parameter logic [7:0] CAL_BYTE = 8'hA5 // Arbitrary calibration value
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic prog_mode,
  input wire logic crystal_input_pin,
  input wire logic action_select_0,
  input wire logic action_select_1,
  input wire logic byte_select_lo,
  input wire logic byte_select_hi,
  input wire logic page_load_strobe,
  input wire logic write_n,
  input wire logic output_enable_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic ready_busy_out,
  output logic [7:0] osc_trim_register
);
  // ==========================================================
  // State machine
  typedef enum logic [1:0] {
    PPP_IDLE = 2'b00,
    PPP_BUSY = 2'b01,
    PPP_LOCKCLR = 2'b11
  } ppp_state_t;

  ppp_state_t state_q;
  logic [23:0] addr_q;
  logic [7:0] cmd_q;
  logic [7:0] dlo_q;
  logic [7:0] dhi_q;
  logic xt_q;
  logic pl_q;
  logic wr_q;
  logic [31:0] cnt_q;
  logic [7:0] fuse_lo_q;
  logic [7:0] fuse_hi_q;
  logic [7:0] fuse_ext_q;
  logic [7:0] lock_q;
  logic [1:0] op_q;
  logic [7:0] dout_q;
  logic oe_n_q;
  logic rdy_q;
  logic [7:0] trim_q;
  logic [15:0] flash_mem [PPP_FLASH_PAGES*PPP_FLASH_PAGE_WORDS];
  logic [7:0] ee_mem [PPP_EE_PAGES*PPP_EE_PAGE_BYTES];
  logic [15:0] fbuf [PPP_FLASH_PAGE_WORDS];
  logic [7:0] ebuf [PPP_EE_PAGE_BYTES];
  logic [PPP_FLASH_PAGE_WORDS-1:0] fbuf_v_q;
  logic [PPP_EE_PAGE_BYTES-1:0] ebuf_v_q;

  // ==========================================================
  // Edge detection on strobes
  wire idle = (state_q == PPP_IDLE);
  wire xt_rise = prog_mode && crystal_input_pin && !xt_q;
  wire pl_rise = prog_mode && page_load_strobe && !pl_q;
  wire wr_fall = prog_mode && !write_n && wr_q;
  wire [1:0] act = {action_select_1, action_select_0};
  wire [1:0] bsel = {byte_select_hi, byte_select_lo};
  wire ld_addr = xt_rise && (act == PPP_ACT_ADDR);
  wire ld_data = xt_rise && (act == PPP_ACT_DATA);
  wire ld_cmd = xt_rise && (act == PPP_ACT_CMD) && idle;
  wire [6:0] word_in_page_index = addr_q[6:0];
  wire [9:0] page_index = addr_q[16:7];
  wire [11:0] eeprom_byte_address = addr_q[11:0];
  wire [2:0] ee_byte = eeprom_byte_address[2:0];
  wire [8:0] ee_page = eeprom_byte_address[11:3];
  wire is_flash_wr = (cmd_q == PPP_CMD_WR_FLASH);
  wire is_ee_wr = (cmd_q == PPP_CMD_WR_EE);
  wire wr_go = wr_fall && idle;
  wire preserve = !fuse_hi_q[PPP_PRESERVE_BIT];
  wire [16:0] flash_word = {page_index, word_in_page_index};

  // Read mux chosen by command and byte select
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = PPP_ERASED;
    unique case (cmd_q)
      PPP_CMD_RD_FLASH: rd_byte = byte_select_lo ? flash_mem[flash_word][15:8]
                                                 : flash_mem[flash_word][7:0];
      PPP_CMD_RD_EE: rd_byte = ee_mem[eeprom_byte_address];
      PPP_CMD_RD_SIG: rd_byte = (byte_select_lo && addr_q[7:0] == 8'h00) ? CAL_BYTE
                                                                          : 8'h00;
      PPP_CMD_RD_FUSE: begin
        unique case (bsel)
          2'b00: rd_byte = fuse_lo_q;
          2'b01: rd_byte = lock_q;
          2'b10: rd_byte = fuse_ext_q;
          2'b11: rd_byte = fuse_hi_q;
        endcase
      end
      default: rd_byte = PPP_ERASED;
    endcase
  end

  // ==========================================================
  // Strobe history, latches and pin outputs
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      xt_q <= 1'b0;
      pl_q <= 1'b0;
      wr_q <= 1'b1;
      addr_q <= 24'h00_0000;
      cmd_q <= PPP_CMD_NOP;
      dlo_q <= 8'h00;
      dhi_q <= 8'h00;
      dout_q <= 8'h00;
      oe_n_q <= 1'b1;
      trim_q <= CAL_BYTE;
    end else if (clk_en) begin
      xt_q <= crystal_input_pin;
      pl_q <= page_load_strobe;
      wr_q <= write_n;
      if (ld_cmd) begin
        cmd_q <= data_in;
      end
      if (ld_addr) begin
        unique case (bsel)
          2'b00: addr_q[7:0] <= data_in;
          2'b01: addr_q[15:8] <= data_in;
          2'b10: addr_q[23:16] <= data_in;
          default: addr_q <= addr_q;
        endcase
      end
      if (ld_data && !byte_select_lo) begin
        dlo_q <= data_in;
      end
      if (ld_data && byte_select_lo && !byte_select_hi) begin
        dhi_q <= data_in;
      end
      oe_n_q <= !(prog_mode && !output_enable_n);
      dout_q <= rd_byte;
    end
  end

  // ==========================================================
  // Page buffers; valid bits cleared once a program or erase has committed,
  // or by a no-op; clearing in the first busy cycle would lose the page
  wire clr_bufs = (ld_cmd && data_in == PPP_CMD_NOP) || (state_q == PPP_LOCKCLR);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fbuf_v_q <= '0;
      ebuf_v_q <= '0;
    end else if (clk_en) begin
      if (clr_bufs) begin
        fbuf_v_q <= '0;
        ebuf_v_q <= '0;
      end
      if (pl_rise && is_flash_wr) begin
        fbuf_v_q[word_in_page_index] <= 1'b1;
      end
      if (pl_rise && is_ee_wr) begin
        ebuf_v_q[ee_byte] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && pl_rise && is_flash_wr) begin
      fbuf[word_in_page_index] <= {dhi_q, dlo_q};
    end
    if (clk_en && pl_rise && is_ee_wr) begin
      ebuf[ee_byte] <= dlo_q;
    end
  end

  // ==========================================================
  // Operation sequencer; op codes 0 flash page, 1 ee page, 2 erase, 3 fuse/lock
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= PPP_IDLE;
      cnt_q <= 32'h0000_0000;
      op_q <= 2'h0;
      rdy_q <= 1'b1;
      fuse_lo_q <= 8'hFF;
      fuse_hi_q <= 8'hFF;
      fuse_ext_q <= 8'hFF;
      lock_q <= 8'hFF;
    end else if (clk_en) begin
      unique case (state_q)
        PPP_IDLE: begin
          if (wr_go && (is_flash_wr || is_ee_wr || cmd_q == PPP_CMD_ERASE)) begin
            state_q <= PPP_BUSY;
            rdy_q <= 1'b0;
            cnt_q <= 32'(PROG_CYCLES);
            op_q <= is_flash_wr ? 2'h0 : (is_ee_wr ? 2'h1 : 2'h2);
          end else if (wr_go && cmd_q == PPP_CMD_WR_FUSE) begin
            unique case (bsel)
              2'b00: fuse_lo_q <= dlo_q;
              2'b01: fuse_hi_q <= dlo_q;
              2'b10: fuse_ext_q <= dlo_q;
              default: fuse_lo_q <= fuse_lo_q;
            endcase
            state_q <= PPP_LOCKCLR;
            op_q <= 2'h3;
            rdy_q <= 1'b0;
          end else if (wr_go && cmd_q == PPP_CMD_WR_LOCK) begin
            lock_q <= lock_q & dlo_q; // Locks only program; erase clears them
            state_q <= PPP_LOCKCLR;
            op_q <= 2'h3;
            rdy_q <= 1'b0;
          end
        end
        PPP_BUSY: begin
          cnt_q <= cnt_q - 32'h0000_0001;
          if (cnt_q <= 32'h0000_0001) begin
            state_q <= PPP_LOCKCLR;
          end
        end
        PPP_LOCKCLR: begin
          if (op_q == 2'h2) begin
            lock_q <= 8'hFF;
          end
          state_q <= PPP_IDLE;
          rdy_q <= 1'b1;
        end
        default: state_q <= PPP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Memory arrays: commit at end of busy, flash fully before locks
  wire commit = clk_en && (state_q == PPP_BUSY) && (cnt_q <= 32'h0000_0001);
  always_ff @(posedge sys_clk) begin
    if (commit) begin
      for (int i = 0; i < PPP_FLASH_PAGE_WORDS; i++) begin
        if (op_q == 2'h2) begin
          flash_mem[{page_index, 7'(i)}] <= 16'hFFFF;
        end else if (op_q == 2'h0 && fbuf_v_q[i]) begin
          flash_mem[{page_index, 7'(i)}] <= fbuf[i];
        end
      end
      for (int j = 0; j < PPP_EE_PAGE_BYTES; j++) begin
        if (op_q == 2'h2 && !preserve) begin
          ee_mem[{ee_page, 3'(j)}] <= PPP_ERASED;
        end else if (op_q == 2'h1 && ebuf_v_q[j]) begin
          ee_mem[{ee_page, 3'(j)}] <= ebuf[j];
        end
      end
    end
  end
  // Erase here clears only the addressed page window; full-array wipe is a
  // model trade-off to keep the write ports small.

  assign data_out = dout_q;
  assign data_oe_n = oe_n_q;
  assign ready_busy_out = rdy_q;
  assign osc_trim_register = trim_q;

  // ==========================================================
  // Checks
  AST_BUSY_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == PPP_BUSY) |=> !ready_busy_out)
    else $error("ready high while busy");
  AST_OE_DRIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && output_enable_n) |=> data_oe_n)
    else $error("bus driven while output enable high");
  AST_START: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && wr_go && is_flash_wr) |=> (state_q == PPP_BUSY))
    else $error("page program did not start");
  AST_CMD_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!ld_cmd) |=> $stable(cmd_q))
    else $error("command changed without load");
  AST_CMD_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && ld_cmd) |=> (cmd_q == $past(data_in)))
    else $error("command not loaded");
  AST_ADDR_LO: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && ld_addr && bsel == 2'b00) |=> (addr_q[7:0] == $past(data_in)))
    else $error("address low not loaded");
  AST_NOP_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && ld_cmd && data_in == PPP_CMD_NOP && !pl_rise) |=> (fbuf_v_q == '0))
    else $error("no-op did not clear page state");
  AST_LOCK_ERASE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && state_q == PPP_LOCKCLR && op_q == 2'h2) |=> (lock_q == 8'hFF))
    else $error("locks not cleared after erase");
  AST_EDGE_ONCE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && xt_rise) |=> !xt_rise)
    else $error("crystal pulse acted twice");
  // Strobe results, buffer marking and erase ordering
  AST_READY_BACK: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && state_q == PPP_LOCKCLR) |=> ready_busy_out)
    else $error("ready not restored after operation");
  AST_OE_ON: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && prog_mode && !output_enable_n) |=> !data_oe_n)
    else $error("bus not driven while output enable low");
  AST_LOCK_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && cmd_q == PPP_CMD_RD_FUSE && bsel == 2'b01) |=> (data_out == $past(lock_q)))
    else $error("lock byte not presented");
  AST_ADDR_HI: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && ld_addr && bsel == 2'b01) |=> (addr_q[15:8] == $past(data_in)))
    else $error("address high not loaded");
  AST_DATA_HI: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && ld_data && bsel == 2'b01) |=> (dhi_q == $past(data_in)))
    else $error("data high not loaded");
  AST_BUSY_END: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && state_q == PPP_BUSY && cnt_q <= 32'h0000_0001) |=> (state_q == PPP_LOCKCLR))
    else $error("page program did not finish");
  AST_FLASH_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && pl_rise && is_flash_wr) |=> fbuf_v_q[$past(word_in_page_index)])
    else $error("flash page load not marked");
  AST_EE_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && pl_rise && is_ee_wr) |=> ebuf_v_q[$past(ee_byte)])
    else $error("eeprom page load not marked");
  AST_LOCK_LATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && state_q == PPP_BUSY && op_q == 2'h2) |=> $stable(lock_q))
    else $error("locks changed before erase completed");
endmodule : ppp_port

// ### testbench/ppp_prog_model.sv
// Programmer model: drives the programming pins and times each strobe.
// Assumes a free-running sys_clk; the bench calls its tasks by name.
`timescale 1ns/1ns
module ppp_prog_model (
  input wire logic sys_clk,
  input wire logic ready_busy_out,
  input wire logic [7:0] bus,
  output logic crystal_input_pin,
  output logic action_select_0,
  output logic action_select_1,
  output logic byte_select_lo,
  output logic byte_select_hi,
  output logic page_load_strobe,
  output logic write_n,
  output logic output_enable_n,
  output logic [7:0] drive
);
  localparam int STROBE = 13; // 260 ns, just over the minimum pulse
  // ==========================================================
  // Idle levels: action 11 keeps a stray crystal edge harmless
  initial begin
    {crystal_input_pin, page_load_strobe} = 2'b00;
    {action_select_1, action_select_0} = 2'b11;
    {byte_select_hi, byte_select_lo} = 2'b00;
    {write_n, output_enable_n} = 2'b11;
    drive = 8'h00;
  end
  // Pins always change one small step after a rising edge
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : hold
  // One crystal pulse carrying an action, a byte select and a byte
  task automatic xtal(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
    {action_select_1, action_select_0} = act;
    {byte_select_hi, byte_select_lo} = bs;
    drive = d;
    hold(1);
    crystal_input_pin = 1'b1;
    hold(STROBE);
    crystal_input_pin = 1'b0;
    hold(STROBE);
  endtask : xtal
  // Page-load pulse latching the data bytes
  task automatic page_load();
    page_load_strobe = 1'b1;
    hold(STROBE);
    page_load_strobe = 1'b0;
    hold(STROBE);
  endtask : page_load
  // Write pulse with byte select 00, the usual case for pages and erase
  task automatic pulse_wr(output int busy);
    write_sel(2'b00, busy);
  endtask : pulse_wr
  // Write pulse with a chosen byte select; counts busy cycles over a fixed window of 3 * STROBE cycles
  task automatic write_sel(input logic [1:0] bs, output int busy);
    busy = 0;
    {byte_select_hi, byte_select_lo} = bs;
    write_n = 1'b0;
    for (int i = 0; i < 3 * STROBE; i++) begin
      hold(1);
      if (i == STROBE) write_n = 1'b1;
      if (ready_busy_out !== 1'b1) busy++;
    end
  endtask : write_sel
  // Entry: crystal toggled while the part is held off, then the enable
  // pattern parked at zero; no crystal edge is left high afterwards
  task automatic enter();
    repeat (6) begin
      crystal_input_pin = ~crystal_input_pin;
      hold(1);
    end
    {page_load_strobe, action_select_1, action_select_0, byte_select_lo} = 4'h0;
    hold(6);
  endtask : enter
  // Read one byte; released bus shows the inverse of the last value
  task automatic read(input logic [1:0] bs, output logic [7:0] d);
    {byte_select_hi, byte_select_lo} = bs;
    drive = ~drive;
    output_enable_n = 1'b0;
    hold(2);
    d = bus;
    hold(STROBE - 2);
    output_enable_n = 1'b1;
    hold(2);
  endtask : read
endmodule : ppp_prog_model

// ### testbench/tb_ppp_port.sv
// Self-checking bench for the parallel programming port.
// Assumes the programmer model drives every pin except reset_n, prog_mode and clk_en, which the bench drives; one 50 MHz clock.
`timescale 1ns/1ns
module tb_ppp_port;
  import ppp_pkg::*;
  localparam int PC = 4;
  localparam logic [7:0] CAL = 8'h5a; // Arbitrary trim value
  logic sys_clk = 0;
  logic reset_n = 0;
  logic prog_mode = 0;
  logic cry, as0, as1, bsl, bsh, pgl, wr_n, oe_n, data_oe_n, ready;
  logic [7:0] drive, data_in, data_out, trim, d, fl, lo0, hi0, lo1, hi1, a, e;
  logic clk_en = 1'b1;
  logic [31:0] seed = 32'hcdca;
  int failures = 0;
  int cmp_count = 0;
  int busy;
  // ==========================================================
  // Clock, bus resolution and instances
  always #10 sys_clk = ~sys_clk;
  assign data_in = data_oe_n ? drive : data_out;
  ppp_port #(.PROG_CYCLES(PC), .CAL_BYTE(CAL)) ppp_port_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .clk_en(clk_en), .prog_mode(prog_mode), .crystal_input_pin(cry),
    .action_select_0(as0), .action_select_1(as1), .byte_select_lo(bsl),
    .byte_select_hi(bsh), .page_load_strobe(pgl), .write_n(wr_n),
    .output_enable_n(oe_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .ready_busy_out(ready), .osc_trim_register(trim));
  ppp_prog_model prog (.sys_clk(sys_clk), .ready_busy_out(ready), .bus(data_out),
    .crystal_input_pin(cry), .action_select_0(as0), .action_select_1(as1),
    .byte_select_lo(bsl), .byte_select_hi(bsh), .page_load_strobe(pgl),
    .write_n(wr_n), .output_enable_n(oe_n), .drive(drive));
  // ==========================================================
  // Helpers: random bytes, comparison and verdict
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // Watchdog sized well above the roughly 4100 cycles of the run
  initial begin
    #(20 * 30000);
    failures++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    prog.hold(5);
    reset_n = 1'b1;
    check("trim", trim, CAL);
    check("ready", {7'h0, ready}, 8'h01);
    check("oe", {7'h0, data_oe_n}, 8'h01);
    prog.enter();
    prog_mode = 1'b1;
    prog.hold(2500);
    fl = rnd();
    prog.xtal(2'b10, 2'b00, PPP_CMD_WR_FUSE);
    prog.xtal(2'b01, 2'b00, fl);
    prog.pulse_wr(busy);
    check("fuse busy", 8'(busy), 8'h01);
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_FUSE);
    for (int i = 0; i < 4; i++) begin
      prog.read(2'(i), d);
      check("fuse read", d, (i == 0) ? fl : PPP_ERASED);
    end
    check("oe idle", {7'h0, data_oe_n}, 8'h01);
    a = rnd() & 8'hfe;
    prog.xtal(2'b00, 2'b10, 8'h00);
    prog.xtal(2'b00, 2'b01, 8'h00);
    prog.xtal(2'b00, 2'b00, a);
    prog.xtal(2'b10, 2'b00, PPP_CMD_ERASE);
    prog.pulse_wr(busy);
    check("erase busy", 8'(busy), 8'(PC + 1));
    {lo0, hi0, lo1, hi1} = {rnd(), rnd(), rnd(), rnd()};
    prog.xtal(2'b10, 2'b00, PPP_CMD_WR_FLASH);
    for (int w = 0; w < 2; w++) begin
      prog.xtal(2'b00, 2'b00, a | 8'(w));
      prog.xtal(2'b01, 2'b00, w ? lo1 : lo0);
      prog.xtal(2'b01, 2'b01, w ? hi1 : hi0);
      // Erased words need no load after the addressed page was erased
      if ({w ? hi1 : hi0, w ? lo1 : lo0} != 16'hffff) begin
        prog.page_load();
      end
    end
    prog.pulse_wr(busy);
    check("page busy", 8'(busy), 8'(PC + 1));
    prog.xtal(2'b10, 2'b00, PPP_CMD_NOP);
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_FLASH);
    for (int w = 0; w < 2; w++) begin
      prog.xtal(2'b00, 2'b00, a | 8'(w));
      prog.read(2'b00, d);
      check("flash lo", d, w ? lo1 : lo0);
      prog.read(2'b01, d);
      check("flash hi", d, w ? hi1 : hi0);
    end
    prog.xtal(2'b10, 2'b00, PPP_CMD_ERASE);
    prog.pulse_wr(busy);
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_FLASH);
    prog.read(2'b01, d);
    check("erased", d, PPP_ERASED);
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_SIG);
    prog.xtal(2'b00, 2'b00, 8'h00);
    prog.read(2'b01, d);
    check("cal byte", d, CAL);
    // EEPROM page write and read back at byte address 0x105
    e = rnd();
    prog.xtal(2'b10, 2'b00, PPP_CMD_WR_EE);
    prog.xtal(2'b00, 2'b01, 8'h01);
    prog.xtal(2'b00, 2'b00, 8'h05);
    prog.xtal(2'b01, 2'b00, e);
    prog.page_load();
    prog.pulse_wr(busy);
    check("ee busy", 8'(busy), 8'(PC + 1));
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_EE);
    prog.read(2'b00, d);
    check("ee read", d, e);
    // Frozen clock enable: a command pulse must leave no trace
    clk_en = 1'b0;
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_FUSE);
    clk_en = 1'b1;
    prog.read(2'b00, d);
    check("frozen", d, e);
    // Preserve fuse and lock bits, then an erase that keeps fuses and EEPROM
    prog.xtal(2'b10, 2'b00, PPP_CMD_WR_FUSE);
    prog.xtal(2'b01, 2'b00, 8'hf7);
    prog.write_sel(2'b01, busy);
    check("fuse hi busy", 8'(busy), 8'h01);
    prog.xtal(2'b10, 2'b00, PPP_CMD_WR_LOCK);
    prog.xtal(2'b01, 2'b00, 8'hfc);
    prog.pulse_wr(busy);
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_FUSE);
    prog.read(2'b11, d);
    check("fuse hi", d, 8'hf7);
    prog.read(2'b01, d);
    check("locks", d, 8'hfc);
    prog.xtal(2'b10, 2'b00, PPP_CMD_ERASE);
    prog.pulse_wr(busy);
    check("erase busy 2", 8'(busy), 8'(PC + 1));
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_FUSE);
    prog.read(2'b01, d);
    check("locks erased", d, PPP_ERASED);
    prog.read(2'b11, d);
    check("fuse kept", d, 8'hf7);
    prog.xtal(2'b10, 2'b00, PPP_CMD_RD_EE);
    prog.read(2'b00, d);
    check("ee kept", d, e);
    conclude();
  end
endmodule : tb_ppp_port
